// ### inc/urs_defs.svh
/*
 * Constants of the receive line status block: register byte addresses,
 * status bit positions, reset values and receiver counts.
 * Assumes a 32-bit APB with byte addresses; included by bare name.
 */
`ifndef URS_DEFS_SVH
`define URS_DEFS_SVH

`define URS_ADDR_RXBUF 32'he0010000
`define URS_ADDR_FCR 32'he0010008
`define URS_ADDR_LSR 32'he0010014
`define URS_ADDR_CFG 32'he0010020
`define URS_ADDR_IRQ_ST 32'he0010024
`define URS_ADDR_IRQ_MASK 32'he0010028

`define URS_LSR_RDR 0
`define URS_LSR_OE 1
`define URS_LSR_PE 2
`define URS_LSR_FE 3
`define URS_LSR_BRK 4

`define URS_FCR_EN 0
`define URS_FCR_RST 1
`define URS_CFG_PAR_EN 16
`define URS_CFG_PAR_ODD 17

`define URS_DIV_RST 16'h0001
`define URS_CFG_RST 18'h00001
`define URS_OS_LAST 4'hf
`define URS_OS_MID 4'h7
`define URS_BIT_LAST 3'h7
`define URS_FIFO_DEPTH 5'h10
`define URS_FIFO_ONE 5'h01
`define URS_WORD_ZERO 32'h00000000

`endif

// ### inc/urs_pkg.sv
/*
 * Types of the receive line status block: receiver states, the FIFO
 * entry that carries a character with its error tags.
 * Assumes urs_defs.svh for all numeric constants.
 */
package urs_pkg;

    typedef enum logic [2:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_PARITY,
        RX_STOP,
        RX_BRK_WAIT
    } urs_state_e;

    typedef struct packed {
        logic brk;
        logic fe;
        logic pe;
        logic [7:0] data;
    } urs_entry_s;

    typedef logic [4:0] urs_irq_t;

endpackage

// ### src/urs_rx_line_status.sv
/*
 * UART receiver with a 16-entry receive FIFO, read-only line status
 * register, event interrupt and an APB slave for software access.
 * Assumes rx_serial_input_i is already synchronous to clk_i, one clock.
 */
// Implementation choice: the APB register port.
// Notes on behaviour
// - Data ready while FIFO holds unread character
// - Overrun flag set at once, read clears
// - Overrun keeps FIFO, drops new character
// - Parity error flag set, read clears
// - Stop bit low sets framing flag
// - Framing error resyncs on bad stop bit
// - Break when line low whole character
// - After break wait for marking level
// - Status read clears the break flag
// - Parity, framing and break flags follow FIFO head character
// - Line status register is read only
`timescale 1ns/1ns
`include "urs_defs.svh"

module urs_rx_line_status
(
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_serial_input_i,
    output logic irq_o
);
    urs_pkg::urs_state_e state_q;
    urs_pkg::urs_entry_s mem_q [16];
    urs_pkg::urs_entry_s rx_entry;
    urs_pkg::urs_entry_s head_new;
    urs_pkg::urs_irq_t irq_st_q;
    urs_pkg::urs_irq_t irq_mask_q;
    urs_pkg::urs_irq_t irq_set;
    logic irq_want;
    logic [31:0] prdata_q;
    logic [31:0] rd_val;
    logic pready_q;
    logic pslverr_q;
    logic irq_q;
    logic acc_start;
    logic acc_done;
    logic mapped;
    logic [17:0] cfg_q;
    logic fifo_en_q;
    logic [15:0] div_cnt_q;
    logic tick;
    logic [3:0] os_cnt_q;
    logic [2:0] bit_cnt_q;
    logic [7:0] shift_q;
    logic par_bad_q;
    logic zero_q;
    logic rx_done;
    logic rx_brk;
    logic [3:0] wr_ptr_q;
    logic [3:0] rd_ptr_q;
    logic [4:0] count_q;
    logic full;
    logic push;
    logic pop;
    logic fifo_rst;
    logic overrun_evt;
    logic head_evt;
    logic oe_q;
    logic pe_flag_q;
    logic fe_flag_q;
    logic brk_flag_q;
    logic lsr_rd_done;
    logic [7:0] lsr_val;

    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;
    assign irq_o = irq_q;

    // APB handshake: one wait state, answer registered
    assign acc_start = psel_i && penable_i && !pready_q;
    assign acc_done = psel_i && penable_i && pready_q;
    assign mapped = (paddr_i == `URS_ADDR_RXBUF) || (paddr_i == `URS_ADDR_FCR) ||
                    (paddr_i == `URS_ADDR_LSR) || (paddr_i == `URS_ADDR_CFG) ||
                    (paddr_i == `URS_ADDR_IRQ_ST) || (paddr_i == `URS_ADDR_IRQ_MASK);
    assign lsr_rd_done = acc_done && !pwrite_i && (paddr_i == `URS_ADDR_LSR);

    assign lsr_val = {3'h0, brk_flag_q, fe_flag_q, pe_flag_q, oe_q, (count_q != 5'h00)};

    always_comb
    begin
        rd_val = `URS_WORD_ZERO;
        unique case (paddr_i)
            `URS_ADDR_RXBUF: rd_val = {24'h000000, mem_q[rd_ptr_q].data};
            `URS_ADDR_FCR: rd_val = {31'h00000000, fifo_en_q};
            `URS_ADDR_LSR: rd_val = {24'h000000, lsr_val};
            `URS_ADDR_CFG: rd_val = {14'h0000, cfg_q};
            `URS_ADDR_IRQ_ST: rd_val = {27'h0000000, irq_st_q};
            `URS_ADDR_IRQ_MASK: rd_val = {27'h0000000, irq_mask_q};
            default: rd_val = `URS_WORD_ZERO;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= `URS_WORD_ZERO;
        end
        else
        begin
            pready_q <= acc_start;
            pslverr_q <= acc_start && !mapped;
            if (acc_start && !pwrite_i)
                prdata_q <= rd_val;
        end
    end

    // Writable control registers; the status register address takes no write
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cfg_q <= `URS_CFG_RST;
            fifo_en_q <= 1'b0;
            irq_mask_q <= 5'h00;
        end
        else if (acc_done && pwrite_i)
        begin
            if (paddr_i == `URS_ADDR_CFG)
                cfg_q <= pwdata_i[17:0];
            if (paddr_i == `URS_ADDR_FCR)
                fifo_en_q <= pwdata_i[`URS_FCR_EN];
            if (paddr_i == `URS_ADDR_IRQ_MASK)
                irq_mask_q <= pwdata_i[4:0];
        end
    end

    // Oversampling tick: sixteen per bit time
    assign tick = (div_cnt_q == 16'h0000);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
            div_cnt_q <= 16'h0000;
        else if (tick)
            div_cnt_q <= 16'(cfg_q[15:0] - 16'h0001);
        else
            div_cnt_q <= 16'(div_cnt_q - 16'h0001);
    end

    // Receive shift register
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= urs_pkg::RX_IDLE;
            os_cnt_q <= 4'h0;
            bit_cnt_q <= 3'h0;
            shift_q <= 8'h00;
            par_bad_q <= 1'b0;
            zero_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                urs_pkg::RX_IDLE:
                begin
                    os_cnt_q <= 4'h0;
                    if (!rx_serial_input_i)
                        state_q <= urs_pkg::RX_START;
                end
                urs_pkg::RX_START:
                begin
                    if (tick && os_cnt_q == `URS_OS_MID)
                    begin
                        os_cnt_q <= 4'h0;
                        bit_cnt_q <= 3'h0;
                        zero_q <= 1'b1;
                        par_bad_q <= 1'b0;
                        state_q <= rx_serial_input_i ? urs_pkg::RX_IDLE : urs_pkg::RX_DATA;
                    end
                    else if (tick)
                    begin
                        os_cnt_q <= 4'(os_cnt_q + 4'h1);
                    end
                end
                urs_pkg::RX_DATA, urs_pkg::RX_PARITY, urs_pkg::RX_STOP:
                begin
                    if (tick && os_cnt_q == `URS_OS_LAST)
                    begin
                        os_cnt_q <= 4'h0;
                        zero_q <= zero_q && !rx_serial_input_i;
                        if (state_q == urs_pkg::RX_DATA)
                        begin
                            shift_q <= {rx_serial_input_i, shift_q[7:1]};
                            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
                            if (bit_cnt_q == `URS_BIT_LAST)
                            begin
                                state_q <= cfg_q[`URS_CFG_PAR_EN] ? urs_pkg::RX_PARITY : urs_pkg::RX_STOP;
                            end
                        end
                        else if (state_q == urs_pkg::RX_PARITY)
                        begin
                            par_bad_q <= (^shift_q ^ rx_serial_input_i) != cfg_q[`URS_CFG_PAR_ODD];
                            state_q <= urs_pkg::RX_STOP;
                        end
                        else if (rx_brk)
                        begin
                            state_q <= urs_pkg::RX_BRK_WAIT;
                        end
                        else if (!rx_serial_input_i)
                        begin
                            bit_cnt_q <= 3'h0;
                            zero_q <= 1'b0;
                            par_bad_q <= 1'b0;
                            state_q <= urs_pkg::RX_DATA;
                        end
                        else
                        begin
                            state_q <= urs_pkg::RX_IDLE;
                        end
                    end
                    else if (tick)
                    begin
                        os_cnt_q <= 4'(os_cnt_q + 4'h1);
                    end
                end
                urs_pkg::RX_BRK_WAIT:
                begin
                    if (rx_serial_input_i)
                        state_q <= urs_pkg::RX_IDLE;
                end
                default:
                    state_q <= urs_pkg::RX_IDLE;
            endcase
        end
    end

    assign rx_done = (state_q == urs_pkg::RX_STOP) && tick && (os_cnt_q == `URS_OS_LAST);
    assign rx_brk = zero_q && !rx_serial_input_i;
    assign rx_entry = '{brk: rx_brk, fe: !rx_serial_input_i, pe: par_bad_q && !rx_brk,
                        data: rx_brk ? 8'h00 : shift_q};

    // Receive FIFO; one entry deep while the FIFO is disabled
    assign fifo_rst = acc_done && pwrite_i && (paddr_i == `URS_ADDR_FCR) && pwdata_i[`URS_FCR_RST];
    assign full = fifo_en_q ? (count_q >= `URS_FIFO_DEPTH) : (count_q >= `URS_FIFO_ONE);
    assign push = rx_done && !full;
    assign overrun_evt = rx_done && full;
    assign pop = acc_done && !pwrite_i && (paddr_i == `URS_ADDR_RXBUF) && (count_q != 5'h00);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || fifo_rst)
        begin
            wr_ptr_q <= 4'h0;
            rd_ptr_q <= 4'h0;
            count_q <= 5'h00;
        end
        else
        begin
            if (push)
            begin
                mem_q[wr_ptr_q] <= rx_entry;
                wr_ptr_q <= 4'(wr_ptr_q + 4'h1);
            end
            if (pop)
                rd_ptr_q <= 4'(rd_ptr_q + 4'h1);
            count_q <= 5'(count_q + {4'h0, push} - {4'h0, pop});
        end
    end

    // A character reaching the FIFO head reports its error tags
    assign head_evt = !fifo_rst && ((push && (count_q == 5'h00 || (pop && count_q == 5'h01))) ||
                                    (pop && count_q > 5'h01));
    assign head_new = (pop && count_q > 5'h01) ? mem_q[4'(rd_ptr_q + 4'h1)] : rx_entry;

    // Clear-on-read flags: clear only what the read returned, set wins
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            oe_q <= 1'b0;
            pe_flag_q <= 1'b0;
            fe_flag_q <= 1'b0;
            brk_flag_q <= 1'b0;
        end
        else
        begin
            oe_q <= overrun_evt || (oe_q && !(lsr_rd_done && prdata_q[`URS_LSR_OE]));
            pe_flag_q <= (head_evt && head_new.pe) ||
                         (pe_flag_q && !(lsr_rd_done && prdata_q[`URS_LSR_PE]));
            fe_flag_q <= (head_evt && head_new.fe) ||
                         (fe_flag_q && !(lsr_rd_done && prdata_q[`URS_LSR_FE]));
            brk_flag_q <= (head_evt && head_new.brk) ||
                          (brk_flag_q && !(lsr_rd_done && prdata_q[`URS_LSR_BRK]));
        end
    end

    // Sticky interrupt status, write one to clear, set wins
    assign irq_set = {head_evt && head_new.brk, head_evt && head_new.fe, head_evt && head_new.pe, overrun_evt, push};
    assign irq_want = |(irq_st_q & irq_mask_q);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            irq_st_q <= 5'h00;
            irq_q <= 1'b0;
        end
        else
        begin
            if (acc_done && pwrite_i && paddr_i == `URS_ADDR_IRQ_ST)
                irq_st_q <= (irq_st_q & ~pwdata_i[4:0]) | irq_set;
            else
                irq_st_q <= irq_st_q | irq_set;
            irq_q <= irq_want;
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_overrun_flag_set: assert property (overrun_evt |=> oe_q)
        else $error("overrun did not set flag");
    a_overrun_fifo_kept: assert property (overrun_evt && !pop && !fifo_rst |=> $stable(count_q) && $stable(wr_ptr_q))
        else $error("overrun changed FIFO");
    a_ready_drops_empty: assert property (pop && !push && count_q == 5'h01 |=> count_q == 5'h00 && !lsr_val[0])
        else $error("data ready not cleared");
    a_parity_flag_set: assert property (head_evt && head_new.pe |=> pe_flag_q)
        else $error("parity flag not set");
    a_framing_resync: assert property (rx_done && !rx_serial_input_i && !zero_q |=> state_q == urs_pkg::RX_DATA)
        else $error("no resync after framing error");
    a_break_stays_idle: assert property (state_q == urs_pkg::RX_BRK_WAIT && !rx_serial_input_i |=>
                                         state_q == urs_pkg::RX_BRK_WAIT && !rx_done)
        else $error("receiver left break wait early");
    a_lsr_read_only: assert property (acc_done && pwrite_i && paddr_i == `URS_ADDR_LSR && !head_evt && !overrun_evt
                                      |=> $stable(lsr_val[4:1]))
        else $error("write changed status");
    a_break_set_wins: assert property (lsr_rd_done && head_evt && head_new.brk |=> brk_flag_q)
        else $error("break lost on read");
    a_read_clears_fe: assert property (lsr_rd_done && prdata_q[`URS_LSR_FE] && !head_evt |=> !fe_flag_q)
        else $error("framing flag not cleared");
    a_irq_follows_mask: assert property (##1 irq_o == $past(irq_want))
        else $error("interrupt level wrong");

    c_overrun: cover property (overrun_evt);
    c_break_seen: cover property (rx_done && rx_brk ##[1:1000] state_q == urs_pkg::RX_IDLE);
    c_framing_resync: cover property (rx_done && !rx_serial_input_i && !zero_q);
    c_status_read: cover property (lsr_rd_done && prdata_q[`URS_LSR_BRK]);

endmodule // urs_rx_line_status

// ### verification/tb_top.sv
/*
 * Self-checking bench: APB read and write tasks, serial frames from the
 * transmitter model, status flags checked against expected values.
 * Assumes the design's map, one bit per 16 clocks at divisor 1.
 */
`timescale 1ns/1ns
`include "urs_defs.svh"

module tb_top;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rx_line;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    logic [7:0] ch;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    always #5 clk = ~clk;

    urs_rx_line_status DUT
    (
        .clk_i(clk),
        .sys_rst_i(sys_rst),
        .psel_i(psel),
        .penable_i(penable),
        .pwrite_i(pwrite),
        .paddr_i(paddr),
        .pwdata_i(pwdata),
        .prdata_o(prdata),
        .pready_o(pready),
        .pslverr_o(pslverr),
        .rx_serial_input_i(rx_line),
        .irq_o(irq)
    );

    urs_tx_model txm
    (
        .clk_i(clk),
        .line_o(rx_line)
    );

    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Setup cycle, access until pready, then release
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rdat, rerr);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string nm);
        apb(1'b0, a, 32'h00000000, rdat, rerr);
        check(nm, rdat, exp);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status after reset");
        apb(1'b0, 32'he0010004, 32'h00000000, rdat, rerr);
        check("unmapped error", {31'h0, rerr}, 32'h00000001);
        check("unmapped data", rdat, 32'h00000000);
        // Divisor 1, even parity
        wr(`URS_ADDR_CFG, 32'h00010001);
        txm.frame(8'h5a, 1'b1, ^8'h5a, 1'b1);
        rd_chk(`URS_ADDR_LSR, 32'h00000001, "status good char");
        check("irq masked", {31'h0, irq}, 32'h00000000);
        rd_chk(`URS_ADDR_IRQ_ST, 32'h00000001, "irq status");
        wr(`URS_ADDR_IRQ_MASK, 32'h00000001);
        repeat (2) @(posedge clk);
        check("irq unmasked", {31'h0, irq}, 32'h00000001);
        wr(`URS_ADDR_IRQ_ST, 32'h00000001);
        repeat (2) @(posedge clk);
        check("irq cleared", {31'h0, irq}, 32'h00000000);
        rd_chk(`URS_ADDR_RXBUF, 32'h0000005a, "rx buffer good");
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status empty");
        // Wrong parity bit
        txm.frame(8'h33, 1'b1, ~^8'h33, 1'b1);
        rd_chk(`URS_ADDR_LSR, 32'h00000005, "status parity");
        rd_chk(`URS_ADDR_LSR, 32'h00000001, "status parity cleared");
        rd_chk(`URS_ADDR_RXBUF, 32'h00000033, "rx buffer parity");
        wr(`URS_ADDR_FCR, 32'h00000001);
        // Stop bit low, then resync on the bad stop bit
        txm.frame(8'h11, 1'b1, ^8'h11, 1'b0);
        repeat (200) @(posedge clk);
        rd_chk(`URS_ADDR_LSR, 32'h00000009, "status framing");
        rd_chk(`URS_ADDR_RXBUF, 32'h00000011, "rx buffer framing");
        rd_chk(`URS_ADDR_LSR, 32'h00000005, "status resync head");
        rd_chk(`URS_ADDR_RXBUF, 32'h000000ff, "rx buffer resync");
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status after resync");
        // Line low longer than a whole character
        txm.hold_low(224);
        apb(1'b0, `URS_ADDR_LSR, 32'h00000000, rdat, rerr);
        check("status break", rdat & 32'h00000013, 32'h00000011);
        rd_chk(`URS_ADDR_RXBUF, 32'h00000000, "rx buffer break");
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status after break");
        // Seventeen characters into a sixteen-deep FIFO
        for (int i = 0; i < 17; i++)
        begin
            ch = i[7:0];
            txm.frame(ch, 1'b1, ^ch, 1'b1);
        end
        wr(`URS_ADDR_LSR, 32'h00000000);
        rd_chk(`URS_ADDR_LSR, 32'h00000003, "status overrun");
        rd_chk(`URS_ADDR_LSR, 32'h00000001, "status overrun cleared");
        for (int i = 0; i < 16; i++)
        begin
            ch = i[7:0];
            rd_chk(`URS_ADDR_RXBUF, {24'h000000, ch}, "rx buffer kept");
        end
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status drained");
        // Odd parity, then parity off, then a FIFO flush
        wr(`URS_ADDR_CFG, 32'h00030001);
        txm.frame(8'h5a, 1'b1, ~^8'h5a, 1'b1);
        rd_chk(`URS_ADDR_LSR, 32'h00000001, "status odd parity");
        rd_chk(`URS_ADDR_RXBUF, 32'h0000005a, "rx buffer odd parity");
        wr(`URS_ADDR_CFG, 32'h00000001);
        txm.frame(8'hc3, 1'b0, 1'b0, 1'b1);
        rd_chk(`URS_ADDR_LSR, 32'h00000001, "status no parity");
        wr(`URS_ADDR_FCR, 32'h00000003);
        rd_chk(`URS_ADDR_LSR, 32'h00000000, "status flushed");
        rd_chk(`URS_ADDR_FCR, 32'h00000001, "fifo enable kept");
        results();
    end
endmodule // tb_top

// ### verification/urs_tx_model.sv
/*
 * Behavioural remote serial transmitter driving the receive line.
 * Assumes a bit time of 16 clocks (divisor 1) and an idle-high line.
 */
`timescale 1ns/1ns

module urs_tx_model
(
    input wire logic clk_i,
    output logic line_o
);
    localparam int BIT_CLKS = 16;

    initial line_o = 1'b1;

    // One bit cell, changed just after a rising edge
    task automatic put_bit(input logic b);
        line_o <= b;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask

    // Start, 8 data bits LSB first, optional parity, stop, one idle bit
    task automatic frame(input logic [7:0] d, input logic par_on, input logic par_v, input logic stop_v);
        @(posedge clk_i);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++)
        begin
            put_bit(d[i]);
        end
        if (par_on)
        begin
            put_bit(par_v);
        end
        put_bit(stop_v);
        put_bit(1'b1);
    endtask

    // Spacing level for n clocks, then back to marking
    task automatic hold_low(input int n);
        @(posedge clk_i);
        line_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        line_o <= 1'b1;
        repeat (BIT_CLKS) @(posedge clk_i);
    endtask
endmodule // urs_tx_model
